// File: rtl/diskette_result_status_bytes.sv
`timescale 1ns/1ps
`default_nettype none
`include "result_status_defs.svh"

module diskette_result_status_bytes (
  input  wire logic                            ref_clk,
  input  wire logic                            reset_n,
  input  wire logic                            clk_en,
  input  wire logic [11:0]                     s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [11:0]                     s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic                            cmd_start,
  input  wire result_status_pkg::command_e     cmd_kind,
  input  wire logic                            cmd_done,
  input  wire logic [1:0]                      cmd_completion,
  input  wire logic [5:0]                      cmd_first_low,
  input  wire result_status_pkg::exec_event_s  exec_event,
  input  wire result_status_pkg::drive_lines_s drive_lines,
  output logic                                 cmd_active
);
  import result_status_pkg::*;

  top_state_s  state_reg;
  top_state_s  state_next;
  logic        active_reg;
  logic        active_next;
  flag_state_s flags;
  logic [7:0]  capture_enable;
  exec_event_s gated_event;

  // Software may mask event classes; a cleared bit drops that class
  always_comb begin
    gated_event = exec_event;
    if (!capture_enable[0]) gated_event.overrun = 1'b0;
    if (!capture_enable[1]) gated_event.deleted_mark_seen = 1'b0;
  end

  error_flag_gen u_flags (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .clk_en        (clk_en),
    .cmd_start     (cmd_start),
    .cmd_kind      (cmd_kind),
    .cmd_active    (active_reg),
    .ev            (gated_event),
    .write_protect (drive_lines.write_protect),
    .flags         (flags)
  );

  always_comb begin
    logic [7:0] dl;
    dl          = 8'h00;
    dl[`DL_WRITE_PROTECT] = drive_lines.write_protect;
    dl[`DL_TRACK_ZERO]    = drive_lines.track_zero;
    dl[`DL_HEAD]          = drive_lines.head_select;
    dl[`DL_DRIVE_HIGH]    = drive_lines.drive_select_high;
    dl[`DL_DRIVE_LOW]     = drive_lines.drive_select_low;
    state_next                   = state_reg;
    state_next.drive_line_status = dl;
    active_next                  = active_reg;
    if (cmd_start) begin
      active_next = 1'b1;
    end else if (cmd_done) begin
      active_next = 1'b0;
      state_next.completion_code = cmd_completion;
      state_next.first_low       = cmd_first_low;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= '0;
      active_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg  <= state_next;
      active_reg <= active_next;
    end
  end

  axil_reg_slave u_bus (
    .ref_clk             (ref_clk),
    .reset_n             (reset_n),
    .clk_en              (clk_en),
    .s_axi_awaddr        (s_axi_awaddr),
    .s_axi_awvalid       (s_axi_awvalid),
    .s_axi_awready       (s_axi_awready),
    .s_axi_wdata         (s_axi_wdata),
    .s_axi_wstrb         (s_axi_wstrb),
    .s_axi_wvalid        (s_axi_wvalid),
    .s_axi_wready        (s_axi_wready),
    .s_axi_bresp         (s_axi_bresp),
    .s_axi_bvalid        (s_axi_bvalid),
    .s_axi_bready        (s_axi_bready),
    .s_axi_araddr        (s_axi_araddr),
    .s_axi_arvalid       (s_axi_arvalid),
    .s_axi_arready       (s_axi_arready),
    .s_axi_rdata         (s_axi_rdata),
    .s_axi_rresp         (s_axi_rresp),
    .s_axi_rvalid        (s_axi_rvalid),
    .s_axi_rready        (s_axi_rready),
    .first_result_byte   ({state_reg.completion_code, state_reg.first_low}),
    .sector_error_status (flags.sector_error_status),
    .data_field_status   (flags.data_field_status),
    .drive_line_status   (state_reg.drive_line_status),
    .capture_enable      (capture_enable)
  );

  assign cmd_active = active_reg;

endmodule : diskette_result_status_bytes
`default_nettype wire

// File: rtl/result_status_defs.svh
`ifndef RESULT_STATUS_DEFS_SVH
`define RESULT_STATUS_DEFS_SVH

// Register byte addresses on the AXI4-Lite slave
`define ADDR_FIRST_RESULT   12'h000
`define ADDR_SECTOR_ERROR   12'h004
`define ADDR_DATA_FIELD     12'h008
`define ADDR_DRIVE_LINE     12'h00c
`define ADDR_EVENT_CAPTURE  12'h010

// Sector error status bit positions
`define SE_END_OF_CYL       7
`define SE_CRC_FAIL         5
`define SE_OVERRUN          4
`define SE_NOT_FOUND        2
`define SE_WRITE_BLOCKED    1
`define SE_MISSING_ID       0

// Data field status bit positions
`define DF_DELETED_MARK     6
`define DF_FIELD_ERROR      5
`define DF_CYL_MISMATCH     4
`define DF_BAD_CYL          1
`define DF_MISSING_DATA     0

// Drive line status bit positions
`define DL_WRITE_PROTECT    6
`define DL_TRACK_ZERO       4
`define DL_HEAD             2
`define DL_DRIVE_HIGH       1
`define DL_DRIVE_LOW        0

// Completion codes, top two bits of the first result byte
`define CC_NORMAL           2'b00
`define CC_ABRUPT           2'b01
`define CC_INVALID          2'b10
`define CC_RESERVED         2'b11

`define CYL_ALL_ONES        8'hff
`define STATUS_RESET        8'h00
// Both event classes start enabled so that the overrun and deleted-mark flags work from reset
`define CAPTURE_RESET       8'h03
`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`endif

// File: rtl/result_status_pkg.sv
package result_status_pkg;

  typedef enum logic [3:0] {
    CMD_READ_DATA,
    CMD_READ_DELETED,
    CMD_READ_ID,
    CMD_READ_TRACK,
    CMD_WRITE_DATA,
    CMD_WRITE_DELETED,
    CMD_FORMAT_TRACK,
    CMD_OTHER
  } command_e;

  // Events reported by the command sequencer while a command runs
  typedef struct packed {
    logic past_last_sector;
    logic id_crc_fail;
    logic data_crc_fail;
    logic overrun;
    logic sector_not_found;
    logic id_unreadable;
    logic start_not_found;
    logic id_mark_missing;
    logic data_mark_missing;
    logic deleted_mark_seen;
    logic cyl_compare;
    logic [7:0] medium_cyl;
    logic [7:0] wanted_cyl;
  } exec_event_s;

  typedef struct packed {
    logic head_select;
    logic drive_select_high;
    logic drive_select_low;
    logic write_protect;
    logic track_zero;
  } drive_lines_s;

  typedef struct packed {
    logic [7:0] sector_error_status;
    logic [7:0] data_field_status;
  } flag_state_s;

  typedef struct packed {
    logic        aw_full;
    logic        w_full;
    logic [11:0] aw_addr;
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic [7:0]  capture;
  } bus_state_s;

  typedef struct packed {
    logic [1:0] completion_code;
    logic [5:0] first_low;
    logic [7:0] drive_line_status;
  } top_state_s;

endpackage : result_status_pkg

// File: rtl/error_flag_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "result_status_defs.svh"

module error_flag_gen (
  input  wire logic                           ref_clk,
  input  wire logic                           reset_n,
  input  wire logic                           clk_en,
  input  wire logic                           cmd_start,
  input  wire result_status_pkg::command_e    cmd_kind,
  input  wire logic                           cmd_active,
  input  wire result_status_pkg::exec_event_s ev,
  input  wire logic                           write_protect,
  output var  result_status_pkg::flag_state_s flags
);
  import result_status_pkg::*;

  flag_state_s state_reg;
  flag_state_s state_next;
  command_e    kind_reg;

  function automatic logic is_write_cmd(input command_e k);
    is_write_cmd = (k == CMD_WRITE_DATA) || (k == CMD_WRITE_DELETED) || (k == CMD_FORMAT_TRACK);
  endfunction : is_write_cmd

  always_comb begin
    logic [7:0] se;
    logic [7:0] df;
    logic       mismatch;
    se       = state_reg.sector_error_status;
    df       = state_reg.data_field_status;
    mismatch = ev.cyl_compare && (ev.medium_cyl != ev.wanted_cyl);
    if (cmd_start) begin
      se = `STATUS_RESET;
      df = `STATUS_RESET;
    end else if (cmd_active) begin
      if (ev.past_last_sector) se[`SE_END_OF_CYL] = 1'b1;
      if (ev.id_crc_fail || ev.data_crc_fail) se[`SE_CRC_FAIL] = 1'b1;
      if (ev.overrun) se[`SE_OVERRUN] = 1'b1;
      if (ev.sector_not_found &&
          (kind_reg == CMD_READ_DATA || kind_reg == CMD_READ_DELETED)) begin
        se[`SE_NOT_FOUND] = 1'b1;
      end
      if ((ev.id_unreadable && kind_reg == CMD_READ_ID) ||
          (ev.start_not_found && kind_reg == CMD_READ_TRACK)) begin
        se[`SE_NOT_FOUND] = 1'b1;
      end
      if (write_protect && is_write_cmd(kind_reg)) se[`SE_WRITE_BLOCKED] = 1'b1;
      if (ev.id_mark_missing) begin
        se[`SE_MISSING_ID]   = 1'b1;
        df[`DF_MISSING_DATA] = 1'b1;
      end
      if (ev.deleted_mark_seen && kind_reg == CMD_READ_DATA) df[`DF_DELETED_MARK] = 1'b1;
      if (ev.data_crc_fail) df[`DF_FIELD_ERROR] = 1'b1;
      if (mismatch) begin
        df[`DF_CYL_MISMATCH] = 1'b1;
        se[`SE_NOT_FOUND]    = 1'b1;
        if (ev.medium_cyl == `CYL_ALL_ONES) df[`DF_BAD_CYL] = 1'b1;
      end
      if (ev.data_mark_missing) df[`DF_MISSING_DATA] = 1'b1;
    end
    se[6] = 1'b0;
    se[3] = 1'b0;
    df[7] = 1'b0;
    df[3] = 1'b0;
    df[2] = 1'b0;
    state_next.sector_error_status = se;
    state_next.data_field_status   = df;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      kind_reg  <= CMD_OTHER;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (cmd_start) begin
        kind_reg <= cmd_kind;
      end
    end
  end

  assign flags = state_reg;

endmodule : error_flag_gen
`default_nettype wire

// File: rtl/axil_reg_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "result_status_defs.svh"

module axil_reg_slave (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  first_result_byte,
  input  wire logic [7:0]  sector_error_status,
  input  wire logic [7:0]  data_field_status,
  input  wire logic [7:0]  drive_line_status,
  output logic [7:0]       capture_enable
);
  import result_status_pkg::*;

  bus_state_s state_reg;
  bus_state_s state_next;
  logic [7:0] wdata_reg;

  function automatic logic [31:0] read_mux(input logic [11:0] a);
    case (a)
      `ADDR_FIRST_RESULT:  read_mux = {24'h000000, first_result_byte};
      `ADDR_SECTOR_ERROR:  read_mux = {24'h000000, sector_error_status};
      `ADDR_DATA_FIELD:    read_mux = {24'h000000, data_field_status};
      `ADDR_DRIVE_LINE:    read_mux = {24'h000000, drive_line_status};
      `ADDR_EVENT_CAPTURE: read_mux = {24'h000000, state_reg.capture};
      default:             read_mux = 32'h00000000;
    endcase
  endfunction : read_mux

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `ADDR_FIRST_RESULT) || (a == `ADDR_SECTOR_ERROR) ||
                (a == `ADDR_DATA_FIELD) || (a == `ADDR_DRIVE_LINE) ||
                (a == `ADDR_EVENT_CAPTURE);
  endfunction : is_mapped

  always_comb begin
    state_next = state_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_full = 1'b1;
    end
    if (state_reg.aw_full && state_reg.w_full && !state_reg.b_valid) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.b_valid = 1'b1;
      // Only the capture word is writable; status words are read-only
      if (state_reg.aw_addr == `ADDR_EVENT_CAPTURE) begin
        state_next.b_resp  = `AXI_RESP_OKAY;
        // Capture write is applied from the latched data word
        state_next.capture = wdata_reg;
      end else begin
        state_next.b_resp = `AXI_RESP_SLVERR;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      state_next.b_valid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.r_valid = 1'b1;
      state_next.r_data  = read_mux(s_axi_araddr);
      state_next.r_resp  = is_mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      state_next.r_valid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg         <= '0;
      state_reg.capture <= `CAPTURE_RESET;
      wdata_reg         <= 8'h00;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]) begin
        wdata_reg <= s_axi_wdata[7:0];
      end
    end
  end

  assign s_axi_awready  = clk_en && !state_reg.aw_full && !state_reg.b_valid;
  assign s_axi_wready   = clk_en && !state_reg.w_full && !state_reg.b_valid;
  assign s_axi_bvalid   = state_reg.b_valid;
  assign s_axi_bresp    = state_reg.b_resp;
  assign s_axi_arready  = clk_en && !state_reg.r_valid;
  assign s_axi_rvalid   = state_reg.r_valid;
  assign s_axi_rdata    = state_reg.r_data;
  assign s_axi_rresp    = state_reg.r_resp;
  assign capture_enable = state_reg.capture;

endmodule : axil_reg_slave
`default_nettype wire

// File: tb/status_checker.sv
`timescale 1ns/1ps
`default_nettype none
module status_checker (
  input wire logic                            ref_clk,
  input wire logic                            reset_n,
  input wire logic                            clk_en,
  input wire logic [11:0]                     s_axi_awaddr,
  input wire logic                            s_axi_awvalid,
  input wire logic                            s_axi_awready,
  input wire logic [1:0]                      s_axi_bresp,
  input wire logic                            s_axi_bvalid,
  input wire logic                            s_axi_bready,
  input wire logic [11:0]                     s_axi_araddr,
  input wire logic                            s_axi_arvalid,
  input wire logic                            s_axi_arready,
  input wire logic [31:0]                     s_axi_rdata,
  input wire logic [1:0]                      s_axi_rresp,
  input wire logic                            s_axi_rvalid,
  input wire logic                            s_axi_rready,
  input wire logic                            cmd_start,
  input wire logic                            cmd_active,
  input wire result_status_pkg::drive_lines_s drive_lines
);
  logic [11:0] rd_addr_reg;
  logic [11:0] wr_addr_reg;
  // Remembers which register the pending answer belongs to
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_addr_reg <= 12'h000;
      wr_addr_reg <= 12'h000;
    end else begin
      if (s_axi_arvalid && s_axi_arready && clk_en) rd_addr_reg <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready && clk_en) wr_addr_reg <= s_axi_awaddr;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready && clk_en;
  endsequence
  // Line byte is only trusted once the lag register has seen settled lines
  sequence lines_settled;
    $past(reset_n) && $past(clk_en) && $stable(drive_lines);
  endsequence
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  sector_resv_a: assert property (s_axi_rvalid && rd_addr_reg == 12'h004 |->
    s_axi_rdata[6] == 1'b0 && s_axi_rdata[3] == 1'b0) else $error("sector reserved bit set");
  field_resv_a: assert property (s_axi_rvalid && rd_addr_reg == 12'h008 |->
    s_axi_rdata[7] == 1'b0 && s_axi_rdata[3:2] == 2'b00) else $error("field reserved bit set");
  drive_byte_a: assert property (ar_taken ##0 lines_settled ##0 s_axi_araddr == 12'h00c |=>
    s_axi_rdata[7:0] == {1'b0, $past(drive_lines.write_protect), 1'b0, $past(drive_lines.track_zero),
    1'b0, $past(drive_lines.head_select), $past(drive_lines.drive_select_high),
    $past(drive_lines.drive_select_low)}) else $error("drive line byte wrong");
  cmd_open_a: assert property (cmd_start && clk_en |=> cmd_active) else $error("command not active");
  wr_refuse_a: assert property (s_axi_bvalid && wr_addr_reg != 12'h010 |-> s_axi_bresp == 2'b10)
    else $error("write not refused");
  rd_refuse_a: assert property (s_axi_rvalid && rd_addr_reg > 12'h010 |->
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  frozen_ready_a: assert property (!clk_en |-> !s_axi_arready && !s_axi_awready)
    else $error("ready while frozen");
  frozen_hold_a: assert property (!clk_en |=> $stable(cmd_active) && $stable(s_axi_rvalid) &&
    $stable(s_axi_bvalid)) else $error("state moved while frozen");
endmodule : status_checker
bind diskette_result_status_bytes status_checker chk (.ref_clk, .reset_n, .clk_en, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .cmd_start, .cmd_active, .drive_lines);
`default_nettype wire

// File: tb/drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_model (
  input  wire logic                            head_sel,
  input  wire logic                            ds_high,
  input  wire logic                            ds_low,
  input  wire logic                            protect_tab,
  input  wire logic                            at_track0,
  output var  result_status_pkg::drive_lines_s lines
);
  // A deselected drive releases its sense lines, which then read inactive
  always_comb begin
    lines.head_select = head_sel;
    lines.drive_select_high = ds_high;
    lines.drive_select_low = ds_low;
    lines.write_protect = (ds_high | ds_low) & protect_tab;
    lines.track_zero = (ds_high | ds_low) & at_track0;
  end
endmodule : drive_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import result_status_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_active;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmd_completion = '0;
  logic cmd_start = 0, cmd_done = 0, head_sel = 0, ds_high = 0, ds_low = 0, protect_tab = 0, at_track0 = 0;
  logic [5:0] cmd_first_low = '0;
  command_e cmd_kind = CMD_OTHER;
  exec_event_s exec_event = '0;
  drive_lines_s drive_lines;
  logic [31:0] seed = 32'h4146, d, v;
  logic [1:0] r, cap_mask = 2'b11;
  int num_errors = 0, comparisons = 0, i;
  always #2 ref_clk = ~ref_clk;
  drive_model drv (.head_sel(head_sel), .ds_high(ds_high), .ds_low(ds_low),
    .protect_tab(protect_tab), .at_track0(at_track0), .lines(drive_lines));
  diskette_result_status_bytes DUT (.ref_clk, .reset_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_start, .cmd_kind, .cmd_done, .cmd_completion,
    .cmd_first_low, .exec_event, .drive_lines, .cmd_active);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic command_e kind_of(input int c);
    case (c)
      4: return CMD_READ_DELETED;
      5: return CMD_READ_ID;
      6: return CMD_READ_TRACK;
      12: return CMD_WRITE_DATA;
      13: return CMD_WRITE_DELETED;
      14: return CMD_FORMAT_TRACK;
      default: return CMD_READ_DATA;
    endcase
  endfunction : kind_of
  function automatic logic [15:0] expect_flags(input int c, input logic [7:0] med, want);
    logic [7:0] se, df;
    se = 8'h00;
    df = 8'h00;
    case (c)
      0: se = 8'h80;
      1: se = 8'h20;
      2: {se, df} = 16'h2020;
      3: se = 8'h10;
      4, 5, 6: se = 8'h04;
      7: {se, df} = 16'h0101;
      8: df = 8'h01;
      9: df = 8'h40;
      10, 11: if (med != want) {se, df} = (med == 8'hff) ? 16'h0412 : 16'h0410;
      12, 13, 14: se = 8'h02;
      default: ;
    endcase
    return {se, df};
  endfunction : expect_flags
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic axi_read(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rs);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check("read_done", n < 50, 1);
  endtask : axi_read
  task automatic axi_write(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] rs);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check("write_done", n < 50, 1);
  endtask : axi_write
  task automatic run_case(input int c);
    exec_event_s ev;
    logic [31:0] x;
    logic [15:0] e;
    ev = '0;
    x = rnd();
    if (c < 12) ev[26 - ((c > 10) ? 10 : c)] = 1'b1;
    ev.medium_cyl = (c == 11) ? 8'hff : x[7:0];
    ev.wanted_cyl = (c == 11) ? 8'h3c : x[15:8];
    e = expect_flags(c, ev.medium_cyl, ev.wanted_cyl);
    // A masked event class leaves its flags clear
    if ((c == 3 && !cap_mask[0]) || (c == 9 && !cap_mask[1])) e = 16'h0;
    @(posedge ref_clk);
    ds_low <= 1'b1;
    protect_tab <= (c >= 12);
    cmd_start <= 1'b1;
    cmd_kind <= kind_of(c);
    cmd_completion <= x[17:16];
    cmd_first_low <= x[23:18];
    @(posedge ref_clk) cmd_start <= 1'b0;
    @(posedge ref_clk) exec_event <= ev;
    @(posedge ref_clk) exec_event <= '0;
    cmd_done <= 1'b1;
    @(posedge ref_clk) cmd_done <= 1'b0;
    axi_read(12'h004, d, r);
    check("sector_error", d, {24'h0, e[15:8]});
    axi_read(12'h008, d, r);
    check("data_field", d, {24'h0, e[7:0]});
    axi_read(12'h000, d, r);
    check("first_result", d, {24'h0, x[17:16], x[23:18]});
  endtask : run_case
  task automatic give_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      axi_read(12'(i * 4), d, r);
      check("reset_value", d, (i == 4) ? 32'h3 : 32'h0);
      check("read_resp", r, (i == 5) ? 2'b10 : 2'b00);
    end
    axi_write(12'h004, 32'hff, r);
    check("ro_write_resp", r, 2'b10);
    axi_read(12'h004, d, r);
    check("ro_unchanged", d, 32'h0);
    axi_write(12'h010, 32'h3, r);
    check("capture_resp", r, 2'b00);
    axi_read(12'h010, d, r);
    check("capture_value", d, 32'h3);
    for (i = 0; i < 16; i++) run_case(i);
    for (i = 0; i < 20; i++) begin
      v = rnd();
      run_case(int'(v[3:0]));
    end
    for (i = 0; i < 10; i++) begin
      v = rnd();
      ds_high <= v[0];
      ds_low <= v[1];
      head_sel <= v[2];
      protect_tab <= v[3];
      at_track0 <= v[4];
      repeat (2) @(posedge ref_clk);
      axi_read(12'h00c, d, r);
      check("drive_line", d, {24'h0, 1'b0, v[3] & (v[0] | v[1]), 1'b0, v[4] & (v[0] | v[1]), 1'b0, v[2], v[0], v[1]});
    end
    axi_write(12'h010, 32'h0, r);
    check("mask_resp", r, 2'b00);
    cap_mask = 2'b00;
    run_case(3);
    run_case(9);
    // Frozen clock enable: readies drop and a start pulse is ignored
    clk_en <= 1'b0;
    cmd_start <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("frozen_ready", s_axi_arready, 0);
    check("frozen_active", cmd_active, 0);
    clk_en <= 1'b1;
    cmd_start <= 1'b0;
    axi_read(12'h010, d, r);
    check("mask_value", d, 32'h0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
